// *** verif/acms_host_model.sv ***
// Host serial-port model: link frames, link clock and the start pin.
// Assumes the bench calls its tasks; link clock stands still between frames.
`timescale 1ns/1ps
module acms_host_model (
  output logic sclk_out,
  output logic cs_n_out,
  output logic fs_out,
  output logic sdi_out,
  output logic start_n_out
);
  initial begin
    sclk_out    = 1'b0;
    cs_n_out    = 1'b1;
    fs_out      = 1'b0;
    sdi_out     = 1'b0;
    start_n_out = 1'b1;
  end
  // Unframed pulses, only to carry reset into the link domain
  task idle(input int n);
    repeat (n) begin
      #7.5 sclk_out = 1'b1;
      #7.5 sclk_out = 1'b0;
    end
  endtask : idle
  // Word MSB first from bit 31; sync marks the first edge
  task frame(input logic [31:0] bits, input int edges, input bit sync);
    cs_n_out = 1'b0;
    for (int e = 0; e < edges; e++) begin
      fs_out  = sync && (e == 0);
      sdi_out = bits[31-e];
      #7.5 sclk_out = 1'b1;
      #7.5 sclk_out = 1'b0;
    end
    fs_out = 1'b0;
    #7.5 cs_n_out = 1'b1;
    // Released line must not keep showing the last bit
    sdi_out = ~sdi_out;
    #30;
  endtask : frame
  // Only driven with chip select high
  task pin(input logic v);
    start_n_out = v;
  endtask : pin
endmodule : acms_host_model

// *** verif/test_acms_sequencer.sv ***
// Self-checking bench of the conversion-mode sequencer with a queue model.
// Assumes the host model drives the link; the bench drives the result bus.
`timescale 1ns/1ps
module test_acms_sequencer;
  import acms_pkg::*;
  logic              clk_in, srst_in, ce_in, sclk, cs_n, fs, sdi, start_n;
  logic [RES_W-1:0]  adc_result_in, data_out, last;
  logic [CFG_W-1:0]  config_register_out;
  logic [CH_W-1:0]   chan_out, ch_conv;
  logic [CNT_W-1:0]  fifo_count_out;
  logic              sample_out, conv_start_out, eoc_out, int_n_out, data_valid_out;
  logic [31:0]       lfsr;
  logic [1:0]        mode;
  logic [RES_W-1:0]  mq[$];
  int                failures, comparisons, nconv, nvalid, cyc, thr, nfz;
  bit                intf, pend, kw;

  acms_host_model i_acms_host_model (.sclk_out(sclk), .cs_n_out(cs_n), .fs_out(fs),
    .sdi_out(sdi), .start_n_out(start_n));
  acms_sequencer i_acms_sequencer (.clk_in(clk_in), .srst_in(srst_in), .ce_in(ce_in),
    .sclk_in(sclk), .cs_n_in(cs_n), .fs_in(fs), .sdi_in(sdi),
    .conversion_start_pin_n_in(start_n), .adc_result_in(adc_result_in),
    .chan_out(chan_out), .sample_out(sample_out), .conv_start_out(conv_start_out),
    .eoc_out(eoc_out), .int_n_out(int_n_out), .data_out(data_out),
    .data_valid_out(data_valid_out), .config_register_out(config_register_out),
    .fifo_count_out(fifo_count_out));

  always #5 clk_in = ~clk_in;

  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt

  task give_verdict;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : give_verdict

  task check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : tick

  // Monitor: new result per conversion, counts of starts and valid pulses
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 40000) begin
      failures++;
      give_verdict;
    end
    if (data_valid_out === 1'b1) nvalid++;
    if (fifo_count_out > 4'h8) check({12'h0, fifo_count_out}, 16'h8);
    if (conv_start_out === 1'b1) begin
      nconv++;
      ch_conv = chan_out;
      check({15'h0, eoc_out}, 16'h0);
      #1 lfsr = nxt(lfsr);
      adc_result_in = lfsr[RES_W-1:0];
      last = lfsr[RES_W-1:0];
    end
  end

  task cfg(input logic [1:0] m, input logic lng, input int t);
    logic [CFG_W-1:0] w;
    w = {2'b00, lng, 2'b00, m, 2'b00, 3'(t - 1)};
    i_acms_host_model.frame({CMD_CFG, w, 16'h0000}, 16, 1'b0);
    tick(8);
    mode = m;
    thr = t;
    mq.delete();
    intf = 0;
    kw = 0;
    pend = 0;
    check({4'h0, config_register_out}, {4'h0, w});
  endtask : cfg

  task cmd(input logic [CMD_W-1:0] c);
    int nv;
    nv = nvalid;
    i_acms_host_model.frame({c, 28'h0}, 4, 1'b0);
    tick(8);
    if (c == CMD_READ) check({4'h0, data_out}, {4'h0, mq.pop_front()});
    else if (kw && mode[0]) pend = 1;
    if (c == CMD_READ || mode == 2'b00) check(16'(nvalid - nv), 16'h1);
    intf = 0;
    kw = 0;
    check({15'h0, int_n_out}, 16'h1);
    check({12'h0, fifo_count_out}, 16'(mq.size()));
  endtask : cmd

  // How: 0 select frame, 1 with frame sync, 2 start pin, 3 long frame
  task conv(input int how, input logic [CH_W-1:0] ch, input bit want);
    int n0;
    n0 = nconv;
    if (how == 2) begin
      i_acms_host_model.pin(1'b0);
      // Start pin fall after the threshold also schedules the clear
      if (kw && mode[0]) pend = 1;
      kw = 0;
      tick(20);
      if (want) check({15'h0, sample_out}, 16'h1);
      i_acms_host_model.pin(1'b1);
    end else begin
      i_acms_host_model.frame({1'b0, ch, 28'h0}, how == 3 ? 28 : 16, how == 1);
      if (kw && mode[0]) pend = 1;
      intf = 0;
      kw = 0;
    end
    for (int k = 0; k < 80 && nconv == n0; k++) tick(1);
    check(16'(nconv - n0), 16'(want));
    if (nconv != n0) begin
      for (int k = 0; k < 500 && eoc_out !== 1'b1; k++) tick(1);
      tick(3);
      check({13'h0, ch_conv}, {13'h0, ch});
      if (mode == 2'b00) begin
        intf = 1;
        check({4'h0, data_out}, {4'h0, last});
      end else begin
        if (pend) mq.delete();
        pend = 0;
        if (mq.size() < FIFO_DEPTH) mq.push_back(last);
        if (mq.size() == thr) begin
          intf = 1;
          kw = 1;
        end
      end
    end
    check({15'h0, int_n_out}, 16'(!intf));
    check({12'h0, fifo_count_out}, 16'(mq.size()));
  endtask : conv

  initial begin
    clk_in = 1'b0;
    srst_in = 1'b1;
    ce_in = 1'b1;
    adc_result_in = 12'h000;
    lfsr = 32'ha1e6;
    // Link edges run on during reset so its synchroniser sees it too
    fork
      i_acms_host_model.idle(8);
      begin
        tick(4);
        srst_in = 1'b0;
      end
    join
    tick(4);
    check({4'h0, config_register_out}, 16'h0000);
    check({14'h0, eoc_out, int_n_out}, 16'h0003);
    // One-shot: select by chip select, convert by start pin, then by a select frame
    cfg(2'b00, 1'b0, 1);
    cmd(4'h3);
    conv(2, 3'h3, 1);
    cmd(4'h4);
    conv(0, 3'h4, 1);
    // Clock enable low freezes the pin synchroniser, so the pulse is lost
    nfz = nconv;
    ce_in = 1'b0;
    i_acms_host_model.pin(1'b0);
    tick(20);
    check({15'h0, sample_out}, 16'h0);
    i_acms_host_model.pin(1'b1);
    tick(20);
    ce_in = 1'b1;
    tick(80);
    check(16'(nconv - nfz), 16'h0);
    // Repeat: one interrupt at threshold, read out, then discard
    cfg(2'b01, 1'b0, 3);
    for (int i = 0; i < 3; i++) conv(i % 2, 3'h5, 1);
    repeat (3) cmd(CMD_READ);
    repeat (4) conv(0, 3'h5, 1);
    // Long sampling: sixteen edges are not enough
    cfg(2'b01, 1'b1, 8);
    conv(0, 3'h2, 0);
    conv(3, 3'h2, 1);
    // Sweep halts at threshold
    cfg(2'b10, 1'b0, 1);
    cmd(4'h0);
    conv(2, 3'h0, 1);
    conv(2, 3'h0, 0);
    // Repeat sweep over two channels carries on
    cfg(2'b11, 1'b0, 2);
    cmd(4'h0);
    conv(2, 3'h0, 1);
    conv(2, 3'h1, 1);
    repeat (2) cmd(CMD_READ);
    conv(2, 3'h0, 1);
    conv(2, 3'h1, 1);
    cmd(4'h0);
    conv(2, 3'h0, 1);
    // Start pulse after the threshold, no command between
    conv(2, 3'h1, 1);
    conv(2, 3'h0, 1);
    give_verdict;
  end
endmodule : test_acms_sequencer

// *** verilog/acms_fifo.sv ***
// Result FIFO of the sequencer: push with pop, or clear with push, in one clock; a clear drops a pop.
// Assumes DEPTH is a power of two; clear then push stores at slot zero.
`timescale 1ns/1ps
module acms_fifo #(
  parameter int WIDTH = acms_pkg::RES_W,
  parameter int DEPTH = acms_pkg::FIFO_DEPTH,
  parameter int CW    = $clog2(DEPTH + 1)
) (
  input  wire logic             clk_in,
  input  wire logic             srst_in,
  input  wire logic             ce_in,
  input  wire logic             clear_in,
  input  wire logic             push_in,
  input  wire logic             pop_in,
  input  wire logic [WIDTH-1:0] din_in,
  output logic      [WIDTH-1:0] dout_out,
  output logic      [CW-1:0]    count_out
);
  import acms_pkg::*;
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    rd_ptr;
  logic [AW-1:0]    wr_ptr;
  logic             do_push;
  logic             do_pop;

  assign do_pop   = pop_in && (count_out != '0) && !clear_in;
  // A full FIFO drops a push unless a clear or a pop frees the slot
  assign do_push  = push_in && (clear_in || do_pop || count_out != CW'(DEPTH));
  assign dout_out = mem[rd_ptr];

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      rd_ptr    <= '0;
      wr_ptr    <= '0;
      count_out <= '0;
    end else if (ce_in) begin
      if (clear_in) begin
        rd_ptr    <= '0;
        wr_ptr    <= AW'(do_push);
        count_out <= CW'(do_push);
      end else begin
        if (do_push) begin
          wr_ptr <= wr_ptr + 1'b1;
        end
        if (do_pop) begin
          rd_ptr <= rd_ptr + 1'b1;
        end
        count_out <= count_out + CW'(do_push) - CW'(do_pop);
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (ce_in && do_push) begin
      mem[clear_in ? '0 : wr_ptr] <= din_in;
    end
  end
endmodule : acms_fifo

// *** verilog/acms_link.sv ***
// Serial-frame decoder on the link clock: command, config word, trigger.
// Assumes the host drives SDI valid at each rising link-clock edge.
`timescale 1ns/1ps
module acms_link (
  input  wire logic                        sclk_in,
  input  wire logic                        srst_in,
  input  wire logic                        cs_n_in,
  input  wire logic                        fs_in,
  input  wire logic                        sdi_in,
  input  wire logic                        long_sample_in,
  output logic      [acms_pkg::CMD_W-1:0]  cmd_out,
  output logic                             cmd_tog_out,
  output logic      [acms_pkg::CFG_W-1:0]  cfg_out,
  output logic                             cfg_tog_out,
  output logic                             trig_tog_out
);
  import acms_pkg::*;
  logic              rst_s1;
  logic              rst_s2;
  logic              long_s1;
  logic              long_s2;
  logic [EDGE_W-1:0] edge_cnt;
  logic [EDGE_W-1:0] next_edge_cnt;
  logic [EDGE_W-1:0] trig_edge;
  logic [CFG_W-2:0]  shift;

  always_ff @(posedge sclk_in) begin
    rst_s1  <= srst_in;
    rst_s2  <= rst_s1;
    long_s1 <= long_sample_in;
    long_s2 <= long_s1;
  end

  // Frame sync restarts the count while chip select stays low
  always_comb begin
    if (fs_in) begin
      next_edge_cnt = 6'h01;
    end else if (edge_cnt == EDGE_MAX) begin
      next_edge_cnt = edge_cnt;
    end else begin
      next_edge_cnt = edge_cnt + 6'h01;
    end
  end

  assign trig_edge = long_s2 ? LONG_EDGE : SHORT_EDGE;

  // Link clock may stop between frames, so chip select ends the count
  always_ff @(posedge sclk_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      edge_cnt <= '0;
    end else if (rst_s2) begin
      edge_cnt <= '0;
    end else begin
      edge_cnt <= next_edge_cnt;
    end
  end

  always_ff @(posedge sclk_in) begin
    if (rst_s2) begin
      shift <= '0;
    end else if (!cs_n_in) begin
      shift <= {shift[CFG_W-3:0], sdi_in};
    end
  end

  always_ff @(posedge sclk_in) begin
    if (rst_s2) begin
      cmd_out      <= '0;
      cmd_tog_out  <= 1'b0;
      cfg_out      <= CFG_RESET;
      cfg_tog_out  <= 1'b0;
      trig_tog_out <= 1'b0;
    end else if (!cs_n_in) begin
      if (next_edge_cnt == CMD_EDGE) begin
        cmd_out     <= {shift[CMD_W-2:0], sdi_in};
        cmd_tog_out <= ~cmd_tog_out;
      end
      if (next_edge_cnt == CFG_EDGE && cmd_out == CMD_CFG) begin
        cfg_out     <= {shift, sdi_in};
        cfg_tog_out <= ~cfg_tog_out;
      end
      if (next_edge_cnt == trig_edge && cmd_out <= CMD_SEL_MAX) begin
        trig_tog_out <= ~trig_tog_out; // [R14]
      end
    end
  end

  chk_trig_edge_count: assert property ( // [R14]
    @(posedge sclk_in) disable iff (rst_s2)
    $changed(trig_tog_out) |-> $past(next_edge_cnt) == $past(trig_edge)
  ) else $error("trigger not on 16th or 28th link edge");
endmodule : acms_link

// *** verilog/acms_pkg.sv ***
// Constants, field layout and mode codes of the conversion-mode sequencer.
// Assumes a 100 MHz system clock; shared by the sequencer, link and FIFO.
package acms_pkg;
  localparam int CFG_W     = 12;
  localparam int RES_W     = 12;
  localparam int CH_W      = 3;
  localparam int CMD_W     = 4;
  localparam int FIFO_DEPTH = 8;
  localparam int CNT_W     = 4;
  localparam int EDGE_W    = 6;
  localparam int CONV_W    = 9;
  // Field positions in config_register
  localparam int MODE_LSB  = 5;
  localparam int LONG_BIT  = 9;
  localparam int THR_LSB   = 0;
  localparam int THR_W     = 3;
  localparam int SWP_LSB   = 3;
  localparam int SWP_W     = 2;
  localparam logic [CFG_W-1:0] CFG_RESET = 12'h000;
  // Host command codes, first four bits of a frame
  localparam logic [CMD_W-1:0] CMD_READ    = 4'he;
  localparam logic [CMD_W-1:0] CMD_CFG     = 4'ha;
  localparam logic [CMD_W-1:0] CMD_SEL_MAX = 4'h7;
  // Link clock edge numbers within a frame
  localparam logic [EDGE_W-1:0] CMD_EDGE   = 6'h04;
  localparam logic [EDGE_W-1:0] CFG_EDGE   = 6'h10;
  localparam logic [EDGE_W-1:0] SHORT_EDGE = 6'h10;
  localparam logic [EDGE_W-1:0] LONG_EDGE  = 6'h1c;
  localparam logic [EDGE_W-1:0] EDGE_MAX   = 6'h3f;
  // Conversion time
  localparam int CONV_NS  = 3860;
  localparam int CLK_MHZ  = 100;
  localparam int CONV_CYC = (CONV_NS * CLK_MHZ + 999) / 1000;
  typedef enum logic [1:0] {
    MODE_ONESHOT = 2'b00,
    MODE_REPEAT  = 2'b01,
    MODE_SWEEP   = 2'b10,
    MODE_RSWEEP  = 2'b11
  } acms_mode_t;
endpackage : acms_pkg

// *** verilog/acms_sequencer.sv ***
// Conversion-mode sequencer: one-shot, repeat, sweep and repeat-sweep.
// Assumes the analog path holds adc_result_in valid at conversion end.
// What this block does
// [R1] Mode 11 works like mode 10 but keeps sweeping past the threshold.
// [R2] Repeat-sweep raises the interrupt once stored results reach the threshold.
// [R3] A read-FIFO cycle after that interrupt keeps results, read in order.
// [R4] Any other cycle or a start pulse empties the FIFO before next store.
// [R5] One-shot extended: chip select selects and reads, start pin converts.
// [R6] One-shot gives one interrupt per conversion and leaves the FIFO alone.
// [R7] Host answers a one-shot interrupt by selecting; old result shifts out.
// [R8] Mode 01 converts the selected channel on each select or sync trigger.
// [R9] Repeat mode raises one interrupt when the FIFO reaches the threshold.
// [R10] Host reads the FIFO to threshold or writes commands to change mode.
// [R11] Repeat mode discards FIFO when the interrupt is served without reading.
// [R12] Config bits 6:5 choose the mode: 00 one-shot, 01 repeat, 10 sweep, 11 repeat-sweep.
// [R13] Sweep visits the sequence channels in order, storing each result.
// [R14] Link triggers start conversion at the 16th or 28th link edge.
// [R15] Start pin falling edge begins sampling, rising edge begins conversion.
// [R16] The FIFO holds at most eight results; threshold never exceeds that.
`timescale 1ns/1ps
module acms_sequencer (
  input  wire logic                        clk_in,
  input  wire logic                        srst_in,
  input  wire logic                        ce_in,
  input  wire logic                        sclk_in,
  input  wire logic                        cs_n_in,
  input  wire logic                        fs_in,
  input  wire logic                        sdi_in,
  input  wire logic                        conversion_start_pin_n_in,
  input  wire logic [acms_pkg::RES_W-1:0]  adc_result_in,
  output logic      [acms_pkg::CH_W-1:0]   chan_out,
  output logic                             sample_out,
  output logic                             conv_start_out,
  output logic                             eoc_out,
  output logic                             int_n_out,
  output logic      [acms_pkg::RES_W-1:0]  data_out,
  output logic                             data_valid_out,
  output logic      [acms_pkg::CFG_W-1:0]  config_register_out,
  output logic      [acms_pkg::CNT_W-1:0]  fifo_count_out
);
  import acms_pkg::*;

  typedef enum logic {ST_IDLE, ST_CONV} acms_state_t;

  function automatic acms_mode_t mode_of(input logic [CFG_W-1:0] cfg);
    return acms_mode_t'(cfg[MODE_LSB +: 2]);
  endfunction : mode_of

  function automatic logic [CNT_W-1:0] thr_of(input logic [CFG_W-1:0] cfg);
    return {1'b0, cfg[THR_LSB +: THR_W]} + 4'h1;
  endfunction : thr_of

  function automatic logic [CH_W-1:0] last_of(input logic [CFG_W-1:0] cfg);
    return {cfg[SWP_LSB +: SWP_W], 1'b1};
  endfunction : last_of

  logic [CFG_W-1:0]  config_register;
  acms_mode_t        mode;
  logic [CNT_W-1:0]  thr;
  logic [CMD_W-1:0]  link_cmd;
  logic [CFG_W-1:0]  link_cfg;
  logic [2:0]        link_tog;
  logic [2:0]        tg_s1;
  logic [2:0]        tg_s2;
  logic [2:0]        tg_s3;
  logic              cst_s1;
  logic              cst_s2;
  logic              cst_s3;
  logic              cmd_ev;
  logic              cfg_ev;
  logic              trig_ev;
  logic              cst_fall;
  logic              cst_rise;
  logic              is_read;
  logic              is_sel;
  logic              sweep;
  logic              discard_mode;
  acms_state_t       state;
  logic [CONV_W-1:0] conv_cnt;
  logic              start;
  logic              done;
  logic              int_flag;
  logic              keep_wait;
  logic              clear_pend;
  logic              halted;
  logic              fifo_push;
  logic              fifo_pop;
  logic              fifo_clear;
  logic              thr_hit;
  logic [CNT_W-1:0]  count_after;
  logic [RES_W-1:0]  fifo_dout;
  logic [CNT_W-1:0]  fifo_count;

  assign mode         = mode_of(config_register); // [R12]
  assign thr          = thr_of(config_register); // [R16]
  assign sweep        = mode[1];
  assign discard_mode = (mode == MODE_REPEAT) || (mode == MODE_RSWEEP);

  acms_link u_link (
    .sclk_in        (sclk_in),
    .srst_in        (srst_in),
    .cs_n_in        (cs_n_in),
    .fs_in          (fs_in),
    .sdi_in         (sdi_in),
    .long_sample_in (config_register[LONG_BIT]),
    .cmd_out        (link_cmd),
    .cmd_tog_out    (link_tog[0]),
    .cfg_out        (link_cfg),
    .cfg_tog_out    (link_tog[1]),
    .trig_tog_out   (link_tog[2])
  );

  // Toggles cross by two flops; words stay still until the next toggle
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      tg_s1  <= '0;
      tg_s2  <= '0;
      tg_s3  <= '0;
      cst_s1 <= 1'b1;
      cst_s2 <= 1'b1;
      cst_s3 <= 1'b1;
    end else if (ce_in) begin
      tg_s1  <= link_tog;
      tg_s2  <= tg_s1;
      tg_s3  <= tg_s2;
      cst_s1 <= conversion_start_pin_n_in;
      cst_s2 <= cst_s1;
      cst_s3 <= cst_s2;
    end
  end

  assign cmd_ev   = tg_s2[0] ^ tg_s3[0];
  assign cfg_ev   = tg_s2[1] ^ tg_s3[1];
  assign trig_ev  = tg_s2[2] ^ tg_s3[2];
  assign cst_fall = cst_s3 && !cst_s2;
  assign cst_rise = !cst_s3 && cst_s2;
  assign is_read  = cmd_ev && (link_cmd == CMD_READ);
  assign is_sel   = cmd_ev && (link_cmd <= CMD_SEL_MAX);

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      config_register <= CFG_RESET;
    end else if (ce_in && cfg_ev) begin
      config_register <= link_cfg;
    end
  end

  // Start pin wins sampling; link frames and the pin both start conversions
  assign start = (trig_ev || cst_rise) && (state == ST_IDLE) && !halted; // [R5] [R8] [R15]
  assign done  = (state == ST_CONV) && (conv_cnt == CONV_W'(CONV_CYC - 1));

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      state          <= ST_IDLE;
      conv_cnt       <= '0;
      conv_start_out <= 1'b0;
    end else if (ce_in) begin
      conv_start_out <= start;
      unique case (state)
        ST_IDLE: begin
          conv_cnt <= '0;
          if (start) begin
            state <= ST_CONV;
          end
        end
        ST_CONV: begin
          conv_cnt <= conv_cnt + 9'h001;
          if (done) begin
            state <= ST_IDLE;
          end
        end
      endcase
    end
  end

  assign eoc_out = (state == ST_IDLE);

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      sample_out <= 1'b0;
    end else if (ce_in) begin
      if (cst_fall) begin
        sample_out <= 1'b1; // [R15]
      end else if (cst_rise || start) begin
        sample_out <= 1'b0;
      end
    end
  end

  // One-shot never touches the FIFO
  assign fifo_push   = done && (mode != MODE_ONESHOT); // [R6] [R12]
  assign fifo_pop    = is_read && (fifo_count != '0);
  assign fifo_clear  = cfg_ev || (fifo_push && clear_pend); // [R4] [R11]
  assign count_after = clear_pend ? 4'h1 : fifo_count + 4'h1 - CNT_W'(fifo_pop);
  assign thr_hit     = fifo_push && (count_after == thr); // [R2] [R9]

  acms_fifo #(
    .WIDTH (RES_W),
    .DEPTH (FIFO_DEPTH),
    .CW    (CNT_W)
  ) u_fifo (
    .clk_in    (clk_in),
    .srst_in   (srst_in),
    .ce_in     (ce_in),
    .clear_in  (fifo_clear),
    .push_in   (fifo_push),
    .pop_in    (fifo_pop),
    .din_in    (adc_result_in),
    .dout_out  (fifo_dout),
    .count_out (fifo_count)
  );

  assign fifo_count_out = fifo_count;

  // Hardware sets win over command clears in the same cycle; a config write clears all
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      int_flag   <= 1'b0;
      keep_wait  <= 1'b0;
      clear_pend <= 1'b0;
      halted     <= 1'b0;
    end else if (ce_in) begin
      if (cfg_ev) begin
        int_flag   <= 1'b0;
        keep_wait  <= 1'b0;
        clear_pend <= 1'b0;
        halted     <= 1'b0;
      end else begin
        int_flag   <= thr_hit || (done && mode == MODE_ONESHOT) || // [R6]
                      (int_flag && !cmd_ev);
        keep_wait  <= thr_hit || (keep_wait && !cmd_ev && !cst_fall);
        clear_pend <= (keep_wait && discard_mode &&
                      ((cmd_ev && !is_read) || cst_fall)) || // [R3] [R4] [R11]
                      (clear_pend && !fifo_push);
        // Mode 11 never halts, so the sweep runs on past the threshold
        halted     <= (thr_hit && mode == MODE_SWEEP) || // [R1]
                      (halted && !(fifo_pop && fifo_count == 4'h1));
      end
    end
  end

  assign int_n_out = !int_flag;

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      data_out       <= '0;
      data_valid_out <= 1'b0;
    end else if (ce_in) begin
      data_valid_out <= fifo_pop || (is_sel && mode == MODE_ONESHOT); // [R7]
      if (done && mode == MODE_ONESHOT) begin
        data_out <= adc_result_in; // [R6]
      end else if (fifo_pop) begin
        data_out <= fifo_dout; // [R3]
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      chan_out <= '0;
    end else if (ce_in) begin
      if (is_sel) begin
        chan_out <= sweep ? '0 : link_cmd[CH_W-1:0]; // [R8]
      end else if (done && sweep) begin
        chan_out <= (chan_out == last_of(config_register)) ? '0 :
                    chan_out + 3'h1; // [R13]
      end
    end
  end

  assign config_register_out = config_register;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (srst_in || !ce_in);

  sequence s_conv_begun;
    conv_start_out && !eoc_out;
  endsequence

  chk_start_converts: assert property ( // [R15]
    start |=> s_conv_begun
  ) else $error("conversion did not begin after a trigger");

  chk_pin_sampling: assert property ( // [R15]
    cst_fall |=> sample_out
  ) else $error("sampling not begun on start pin fall");

  chk_oneshot_nofifo: assert property ( // [R6]
    (done && mode == MODE_ONESHOT) |=> int_flag && data_out == $past(adc_result_in)
                                       && fifo_count == $past(fifo_count)
  ) else $error("one-shot result or interrupt wrong");

  chk_thr_interrupt: assert property ( // [R2]
    (thr_hit && mode != MODE_ONESHOT) |=> !int_n_out && fifo_count == $past(thr)
  ) else $error("interrupt missing at threshold");

  chk_repeat_single: assert property ( // [R9]
    ($rose(int_flag) && mode == MODE_REPEAT) |-> fifo_count == thr
  ) else $error("repeat interrupt away from threshold");

  chk_read_keeps: assert property ( // [R3]
    (keep_wait && is_read && !clear_pend) |=> !clear_pend
  ) else $error("read after interrupt marked FIFO for clearing");

  chk_rsweep_clear: assert property ( // [R4]
    (keep_wait && cmd_ev && !is_read && mode == MODE_RSWEEP && !cfg_ev) |=> clear_pend
  ) else $error("repeat-sweep did not plan FIFO clear");

  chk_repeat_discard: assert property ( // [R11]
    (clear_pend && fifo_push && mode == MODE_REPEAT) |=> fifo_count == 4'h1
  ) else $error("repeat mode kept stale FIFO data");

  chk_rsweep_runs: assert property ( // [R1]
    mode == MODE_RSWEEP && !$past(cfg_ev) |-> !halted
  ) else $error("repeat-sweep halted at threshold");

  chk_sweep_wrap: assert property ( // [R13]
    (done && sweep && !is_sel && chan_out == last_of(config_register)) |=> chan_out == '0
  ) else $error("sweep did not wrap to first channel");

  chk_fifo_bound: assert property ( // [R16]
    fifo_count <= CNT_W'(FIFO_DEPTH) && thr <= CNT_W'(FIFO_DEPTH)
  ) else $error("FIFO count or threshold above depth");
endmodule : acms_sequencer
